// >>> hdl/gpio_config_registers.sv
// pin configuration registers, pin interrupt and converter pin control
// What this block does
// [RULE1] first config register at 1b, read/write
// [RULE2] second config register at 1c, read/write
// [RULE3] direction bits for pins two and one
// [RULE4] output level bits, effective in output mode
// [RULE5] polarity: rising/low or falling/high detection
// [RULE6] pin one may request converter standby
// [RULE7] pin one may switch buck a
// [RULE8] pin three direction and output level
// [RULE9] bit enables the always-on regulator
// [RULE10] bit selects charge voltage; bit three unused
// [RULE11] pins one and two as interrupt sources
// [RULE12] pin two level switches buck b on
// [RULE13] interrupt clears after two edges plus read
// [RULE14] undervoltage or output mode drops the interrupt
// [RULE15] pin three edge starts a conversion
// [RULE16] two-stage synchroniser on every pin input
`timescale 1ns/1ps
module gpio_config_registers (
  input wire logic clk,
  input wire logic rst,
  input gpio_cfg_pkg::reg_req_t req,
  output logic [7:0] rd_data,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  input wire logic uvlo,
  input wire logic adc_trig_enable,
  input wire logic adc_trig_rising,
  output logic int_n,
  output logic buck_a_pin_on,
  output logic buck_b_pin_on,
  output logic buck_standby_req,
  output logic always_on_reg_enable,
  output logic charge_voltage_select,
  output logic adc_start
);
  logic [7:0] cfg12_ff;
  logic [7:0] cfg3_ff;
  logic [7:0] rd_data_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] prev_ff;
  logic [2:0] pin_out_ff;
  logic [2:0] pin_oe_ff;
  gpio_cfg_pkg::irq_state_t irq_st_ff [2];
  gpio_cfg_pkg::irq_state_t nxt_irq_st [2];
  logic int_n_ff;
  logic buck_a_ff;
  logic buck_b_ff;
  logic standby_ff;
  logic aon_ff;
  logic chg_ff;
  logic adc_start_ff;
  logic [1:0] dir12;
  logic [1:0] pol12;
  logic [1:0] irq_en;

  // edge of the selected polarity: 0 rising, 1 falling
  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic pol);
    edge_hit = pol ? (prev & ~cur) : (~prev & cur);
  endfunction : edge_hit

  // level of the selected polarity: 0 low, 1 high
  function automatic logic level_hit(input logic cur, input logic pol);
    level_hit = (cur == pol);
  endfunction : level_hit

  assign dir12 = {cfg12_ff[gpio_cfg_pkg::B_P2_DIR],
                  cfg12_ff[gpio_cfg_pkg::B_P1_DIR]};
  assign pol12 = {cfg12_ff[gpio_cfg_pkg::B_P2_POL],
                  cfg12_ff[gpio_cfg_pkg::B_P1_POL]};
  assign irq_en = {cfg3_ff[gpio_cfg_pkg::B_P2_IRQ],
                   cfg3_ff[gpio_cfg_pkg::B_P1_IRQ]};

  // register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg12_ff <= gpio_cfg_pkg::RST_PIN12;
      cfg3_ff <= gpio_cfg_pkg::RST_PIN3;
    end else if (req.wr) begin
      if (req.addr == gpio_cfg_pkg::ADDR_PIN12) begin
        cfg12_ff <= req.wdata; // [RULE1]
      end
      if (req.addr == gpio_cfg_pkg::ADDR_PIN3) begin
        cfg3_ff <= req.wdata; // [RULE2]
      end
    end
  end

  // read data holds until the next read; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= gpio_cfg_pkg::RD_UNMAPPED;
    end else if (req.rd) begin
      case (req.addr)
        gpio_cfg_pkg::ADDR_PIN12: rd_data_ff <= cfg12_ff; // [RULE1]
        gpio_cfg_pkg::ADDR_PIN3: rd_data_ff <= cfg3_ff; // [RULE2]
        default: rd_data_ff <= gpio_cfg_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // pin inputs; only sync2 and prev are looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      sync1_ff <= pin_in; // [RULE16]
      sync2_ff <= sync1_ff; // [RULE16]
      prev_ff <= sync2_ff;
    end
  end

  // open drain: a high level releases the pin, a low level pulls it down
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_ff <= 3'h0;
      pin_oe_ff <= 3'h0;
    end else begin
      pin_out_ff <= {cfg3_ff[gpio_cfg_pkg::B_P3_LVL],
                     cfg12_ff[gpio_cfg_pkg::B_P2_LVL],
                     cfg12_ff[gpio_cfg_pkg::B_P1_LVL]}; // [RULE4] [RULE8]
      pin_oe_ff[0] <= dir12[0] &
                      ~cfg12_ff[gpio_cfg_pkg::B_P1_LVL]; // [RULE3] [RULE4]
      pin_oe_ff[1] <= dir12[1] &
                      ~cfg12_ff[gpio_cfg_pkg::B_P2_LVL]; // [RULE3] [RULE4]
      pin_oe_ff[2] <= cfg3_ff[gpio_cfg_pkg::B_P3_DIR] &
                      ~cfg3_ff[gpio_cfg_pkg::B_P3_LVL]; // [RULE8]
    end
  end

  // per-pin interrupt tracker: assert on the chosen edge, arm on the next
  // edge, release on a host read once armed, or at once on undervoltage or output mode
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_irq_st[i] = irq_st_ff[i];
      if (uvlo || dir12[i]) begin
        nxt_irq_st[i] = gpio_cfg_pkg::IRQ_IDLE; // [RULE14]
      end else begin
        case (irq_st_ff[i])
          gpio_cfg_pkg::IRQ_IDLE: begin
            if (irq_en[i] &&
                edge_hit(sync2_ff[i], prev_ff[i], pol12[i])) begin
              nxt_irq_st[i] = gpio_cfg_pkg::IRQ_FIRST; // [RULE11] [RULE5]
            end
          end
          gpio_cfg_pkg::IRQ_FIRST: begin
            if (sync2_ff[i] != prev_ff[i]) begin
              nxt_irq_st[i] = gpio_cfg_pkg::IRQ_SECOND; // [RULE13]
            end
          end
          gpio_cfg_pkg::IRQ_SECOND: begin
            if (req.rd) begin
              nxt_irq_st[i] = gpio_cfg_pkg::IRQ_IDLE; // [RULE13]
            end
          end
          default: nxt_irq_st[i] = gpio_cfg_pkg::IRQ_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_st_ff[0] <= gpio_cfg_pkg::IRQ_IDLE;
      irq_st_ff[1] <= gpio_cfg_pkg::IRQ_IDLE;
      int_n_ff <= 1'b1;
    end else begin
      irq_st_ff[0] <= nxt_irq_st[0];
      irq_st_ff[1] <= nxt_irq_st[1];
      int_n_ff <= (irq_st_ff[0] == gpio_cfg_pkg::IRQ_IDLE) &&
                  (irq_st_ff[1] == gpio_cfg_pkg::IRQ_IDLE); // [RULE11]
    end
  end

  // converter pin commands; a disabled pin control leaves the converter
  // to its own register command, so it reports "on"
  always_ff @(posedge clk) begin
    if (rst) begin
      buck_a_ff <= 1'b1;
      buck_b_ff <= 1'b1;
      standby_ff <= 1'b0;
    end else begin
      buck_a_ff <= cfg12_ff[gpio_cfg_pkg::B_P1_BUCKA] ?
                   (~dir12[0] & level_hit(sync2_ff[0], pol12[0]))
                   : 1'b1; // [RULE7] [RULE5]
      buck_b_ff <= cfg3_ff[gpio_cfg_pkg::B_P2_BUCKB] ?
                   (~dir12[1] & level_hit(sync2_ff[1], pol12[1]))
                   : 1'b1; // [RULE12]
      standby_ff <= cfg12_ff[gpio_cfg_pkg::B_P1_SBY] & ~dir12[0] &
                    level_hit(sync2_ff[0], pol12[0]); // [RULE6]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aon_ff <= 1'b0;
      chg_ff <= 1'b0;
    end else begin
      aon_ff <= cfg3_ff[gpio_cfg_pkg::B_AON_EN]; // [RULE9]
      chg_ff <= cfg3_ff[gpio_cfg_pkg::B_CHG_SEL]; // [RULE10]
    end
  end

  // conversion start pulse, one cycle per selected edge
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_start_ff <= 1'b0;
    end else begin
      adc_start_ff <= adc_trig_enable & ~cfg3_ff[gpio_cfg_pkg::B_P3_DIR] &
                      edge_hit(sync2_ff[2], prev_ff[2],
                               ~adc_trig_rising); // [RULE15]
    end
  end

  assign rd_data = rd_data_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign int_n = int_n_ff;
  assign buck_a_pin_on = buck_a_ff;
  assign buck_b_pin_on = buck_b_ff;
  assign buck_standby_req = standby_ff;
  assign always_on_reg_enable = aon_ff;
  assign charge_voltage_select = chg_ff;
  assign adc_start = adc_start_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_write_pin12: assert property ( // [RULE1]
    req.wr && req.addr == gpio_cfg_pkg::ADDR_PIN12
    |=> cfg12_ff == $past(req.wdata))
    else $error("first register write lost");
  a_read_pin12: assert property ( // [RULE1]
    req.rd && req.addr == gpio_cfg_pkg::ADDR_PIN12
    |=> rd_data == $past(cfg12_ff))
    else $error("first register read wrong");
  a_write_pin3: assert property ( // [RULE2]
    req.wr && req.addr == gpio_cfg_pkg::ADDR_PIN3
    |=> cfg3_ff == $past(req.wdata))
    else $error("second register write lost");
  a_input_no_drive: assert property ( // [RULE3]
    !dir12[0] |=> !pin_oe[0])
    else $error("pin one driven while input");
  a_low_drive: assert property ( // [RULE4]
    dir12[1] && !cfg12_ff[gpio_cfg_pkg::B_P2_LVL] |=> pin_oe[1] && !pin_out[1])
    else $error("pin two not pulled low");
  a_standby_req: assert property ( // [RULE6]
    !cfg12_ff[gpio_cfg_pkg::B_P1_SBY] |=> !buck_standby_req)
    else $error("standby requested while disabled");
  a_buck_a_free: assert property ( // [RULE7]
    !cfg12_ff[gpio_cfg_pkg::B_P1_BUCKA] |=> buck_a_pin_on)
    else $error("buck a held off by disabled pin");
  a_pin3_drive: assert property ( // [RULE8]
    cfg3_ff[gpio_cfg_pkg::B_P3_DIR] && !cfg3_ff[gpio_cfg_pkg::B_P3_LVL]
    |=> pin_oe[2])
    else $error("pin three not driven");
  a_aon_follow: assert property ( // [RULE9]
    req.wr && req.addr == gpio_cfg_pkg::ADDR_PIN3
    |=> ##1 always_on_reg_enable == $past(req.wdata[5], 2))
    else $error("regulator enable not following");
  a_chg_follow: assert property ( // [RULE10]
    req.wr && req.addr == gpio_cfg_pkg::ADDR_PIN3
    |=> ##1 charge_voltage_select == $past(req.wdata[4], 2))
    else $error("charge voltage select not following");
  a_irq_assert: assert property ( // [RULE11]
    irq_st_ff[0] == gpio_cfg_pkg::IRQ_IDLE && irq_en[0] && !dir12[0] &&
    !uvlo && edge_hit(sync2_ff[0], prev_ff[0], pol12[0]) |=> ##1 !int_n)
    else $error("interrupt not asserted on pin edge");
  a_irq_hold: assert property ( // [RULE13]
    irq_st_ff[1] == gpio_cfg_pkg::IRQ_FIRST && !uvlo && !dir12[1]
    |=> irq_st_ff[1] != gpio_cfg_pkg::IRQ_IDLE)
    else $error("interrupt released before second edge");
  a_irq_release: assert property ( // [RULE14]
    uvlo |=> ##1 int_n)
    else $error("undervoltage did not drop interrupt");
  a_buck_b_level: assert property ( // [RULE12]
    cfg3_ff[gpio_cfg_pkg::B_P2_BUCKB] && !dir12[1] &&
    sync2_ff[1] == pol12[1] |=> buck_b_pin_on)
    else $error("buck b not on at selected level");
  a_adc_cause: assert property ( // [RULE15]
    adc_start |-> $past(adc_trig_enable) &&
    $past(sync2_ff[2]) != $past(prev_ff[2]))
    else $error("conversion start without pin edge");
  a_sync_depth: assert property ( // [RULE16]
    $rose(pin_in[0]) ##1 pin_in[0] |=> sync2_ff[0])
    else $error("synchroniser depth wrong");

  c_irq_cycle: cover property (!int_n ##[1:50] int_n);
  c_buck_b_on: cover property (cfg3_ff[0] && !dir12[1] ##1 buck_b_pin_on);
  c_adc_go: cover property (adc_start);
  c_standby: cover property (buck_standby_req);
endmodule : gpio_config_registers

// >>> inc/gpio_cfg_pkg.sv
// constants and types for the pin configuration register block
package gpio_cfg_pkg;
  localparam logic [7:0] ADDR_PIN12 = 8'h1b;
  localparam logic [7:0] ADDR_PIN3 = 8'h1c;
  localparam logic [7:0] RST_PIN12 = 8'h00;
  localparam logic [7:0] RST_PIN3 = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // first configuration register fields
  localparam int B_P2_DIR = 7;
  localparam int B_P1_DIR = 6;
  localparam int B_P2_LVL = 5;
  localparam int B_P1_LVL = 4;
  localparam int B_P2_POL = 3;
  localparam int B_P1_POL = 2;
  localparam int B_P1_SBY = 1;
  localparam int B_P1_BUCKA = 0;
  // second configuration register fields, bit 3 stored but unused
  localparam int B_P3_DIR = 7;
  localparam int B_P3_LVL = 6;
  localparam int B_AON_EN = 5;
  localparam int B_CHG_SEL = 4;
  localparam int B_P2_IRQ = 2;
  localparam int B_P1_IRQ = 1;
  localparam int B_P2_BUCKB = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_FIRST = 2'b01,
    IRQ_SECOND = 2'b10
  } irq_state_t;
endpackage : gpio_cfg_pkg

// >>> verif/pin_source_model.sv
// external sources on the three pins, open-drain wire resolution
`timescale 1ns/1ps
module pin_source_model (
  input wire logic [2:0] drv,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_in
);
  // pull-up wins when nobody sinks; device sink forces low
  assign pin_in = ~pin_oe & drv;
endmodule : pin_source_model

// >>> verif/tb_gpio_config_registers.sv
// self-checking bench for the pin configuration register block
`timescale 1ns/1ps
module tb_gpio_config_registers;
  logic clk, rst, uvlo, trg_en, trg_rise, rd_pend;
  gpio_cfg_pkg::reg_req_t req;
  logic [7:0] rd_data, d, e;
  logic [2:0] pin_in, pin_out, pin_oe, drv;
  logic int_n, bka, bkb, sby, aon, chg, adc;
  logic [7:0] q[$];
  int miscompares = 0;
  int comparisons = 0;
  gpio_config_registers DUT (.clk(clk), .rst(rst), .req(req),
    .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .uvlo(uvlo), .adc_trig_enable(trg_en), .adc_trig_rising(trg_rise),
    .int_n(int_n), .buck_a_pin_on(bka), .buck_b_pin_on(bkb),
    .buck_standby_req(sby), .always_on_reg_enable(aon),
    .charge_voltage_select(chg), .adc_start(adc));
  pin_source_model src (.drv(drv), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task summarize;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] v);
    @(negedge clk);
    req.wr = 1;
    req.addr = a;
    req.wdata = v;
    @(negedge clk);
    req.wr = 0;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] x);
    @(negedge clk);
    req.rd = 1;
    req.addr = a;
    q.push_back(x);
    @(negedge clk);
    req.rd = 0;
  endtask : rd
  // bounded wait for a one-bit output to reach a level
  task automatic wait_for(string n, ref logic s, input logic v);
    int i;
    for (i = 0; i < 10 && s !== v; i++) @(negedge clk);
    chk(n, {7'h0, v}, {7'h0, s});
    if (s !== v) summarize();
  endtask : wait_for
  always @(posedge clk) rd_pend <= req.rd & ~rst;
  // read data lands one edge after the strobe and stands until next read
  always @(negedge clk)
    if (rd_pend) chk("rd_data", q.pop_front(), rd_data);
  initial begin
    rst = 1; uvlo = 0; trg_en = 0; trg_rise = 1; drv = 0; req = '0;
    void'($urandom(32'h1a08));
    repeat (12) @(negedge clk);
    rst = 0;
    rd(gpio_cfg_pkg::ADDR_PIN12, gpio_cfg_pkg::RST_PIN12);
    rd(gpio_cfg_pkg::ADDR_PIN3, gpio_cfg_pkg::RST_PIN3);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      e = $urandom;
      wr(gpio_cfg_pkg::ADDR_PIN12, d);
      wr(gpio_cfg_pkg::ADDR_PIN3, e);
      wr(8'h55, ~d);
      rd(gpio_cfg_pkg::ADDR_PIN12, d);
      rd(gpio_cfg_pkg::ADDR_PIN3, e);
      rd(8'h55, gpio_cfg_pkg::RD_UNMAPPED);
      chk("aon", {7'h0, e[5]}, {7'h0, aon});
      chk("chg", {7'h0, e[4]}, {7'h0, chg});
      chk("oe", {5'h0, e[7] & ~e[6], d[7] & ~d[5], d[6] & ~d[4]},
          {5'h0, pin_oe});
      chk("pin_out", {5'h0, e[6], d[5], d[4]},
          {5'h0, pin_out});
    end
    // pin one then pin two interrupt: two edges then a read release it;
    // pin one is dropped by undervoltage, pin two by output mode
    for (int k = 0; k < 2; k++) begin
      wr(gpio_cfg_pkg::ADDR_PIN12, 8'h00);
      wr(gpio_cfg_pkg::ADDR_PIN3, 8'h02 << k);
      repeat (5) @(negedge clk);
      drv = 3'b001 << k;
      wait_for("int_n", int_n, 0);
      rd(gpio_cfg_pkg::ADDR_PIN3, 8'h02 << k);
      repeat (4) @(negedge clk);
      chk("int_n", 8'h00, {7'h0, int_n});
      drv = 3'b000;
      repeat (6) @(negedge clk);
      chk("int_n", 8'h00, {7'h0, int_n});
      rd(gpio_cfg_pkg::ADDR_PIN3, 8'h02 << k);
      wait_for("int_n", int_n, 1);
      drv = 3'b001 << k;
      wait_for("int_n", int_n, 0);
      if (k == 0) uvlo = 1;
      else wr(gpio_cfg_pkg::ADDR_PIN12, 8'h80);
      wait_for("int_n", int_n, 1);
      uvlo = 0;
      drv = 3'b000;
    end
    // level control of the converters under both polarities
    for (int p = 0; p < 2; p++) begin
      wr(gpio_cfg_pkg::ADDR_PIN12, {4'h0, p[0], p[0], 2'b11});
      wr(gpio_cfg_pkg::ADDR_PIN3, 8'h01);
      for (int l = 0; l < 2; l++) begin
        drv = {1'b0, l[0], l[0]};
        repeat (6) @(negedge clk);
        chk("buck_a", {7'h0, l == p}, {7'h0, bka});
        chk("buck_b", {7'h0, l == p}, {7'h0, bkb});
        chk("standby", {7'h0, l == p}, {7'h0, sby});
      end
    end
    // pin three rising edge starts a conversion
    wr(gpio_cfg_pkg::ADDR_PIN3, 8'h00);
    trg_en = 1;
    repeat (5) @(negedge clk);
    drv = 3'b100;
    wait_for("adc_start", adc, 1);
    @(negedge clk);
    chk("adc_start", 8'h00, {7'h0, adc});
    // falling edge select on the same pin
    trg_rise = 0;
    drv = 3'b000;
    wait_for("adc_start", adc, 1);
    @(negedge clk);
    chk("adc_start", 8'h00, {7'h0, adc});
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule : tb_gpio_config_registers
